// *** logic/lcdi2c_defs.svh ***
// Purpose: constants for the display driver write-only serial slave
// Assumes: 40 MHz system clock
// Notes: definitions only
`ifndef LCDI2C_DEFS_SVH
`define LCDI2C_DEFS_SVH
`define LCDI2C_ADDR_HI6 6'h1c
`define LCDI2C_CTL_MORE_BIT 7
`define LCDI2C_CTL_DATA_BIT 6
`define LCDI2C_FRAME_PERIODS 5'h18
`define LCDI2C_PTR_W 7
`endif

// *** logic/lcdi2c_pkg.sv ***
// Purpose: types for the display driver write-only serial slave
// Assumes: used with lcdi2c_defs.svh
// Notes: no constants here
package lcdi2c_pkg;
	typedef enum logic [1:0] {
		LCDI2C_PH_ADDR,
		LCDI2C_PH_CTRL,
		LCDI2C_PH_PAYLOAD,
		LCDI2C_PH_IGNORE
	} lcdi2c_phase_e;

	typedef struct packed {
		logic [6:0] ptr;
		logic [2:0] subaddr;
		logic [7:0] data;
	} lcdi2c_ram_wr_s;

	typedef struct packed {
		logic [2:0] hw_subaddr;
		logic addr_lsb_strap;
	} lcdi2c_straps_s;
endpackage

// *** logic/lcdi2c_sync2.sv ***
// Purpose: two-stage synchroniser for pin inputs
// Assumes: single clock domain
// Notes: first stage feeds only the second
`timescale 1ns/100ps
module lcdi2c_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '1;
			q <= '1;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// *** logic/lcdi2c_frame_div.sv ***
// Purpose: frame tick every 24 display clock periods
// Assumes: disp_clk_tick is a one-cycle enable per display clock period
// Notes: display clock rate itself is set elsewhere
`timescale 1ns/100ps
`include "lcdi2c_defs.svh"
module lcdi2c_frame_div (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic disp_clk_tick,
	output logic frame_tick
);
	logic [4:0] cnt_reg;
	logic [4:0] cnt_next;
	logic frame_next;

	always_comb begin
		cnt_next = cnt_reg;
		frame_next = 1'b0;
		if (disp_clk_tick) begin
			if (cnt_reg == `LCDI2C_FRAME_PERIODS - 5'h01) begin
				cnt_next = 5'h00;
				frame_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 5'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 5'h00;
			frame_tick <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			frame_tick <= frame_next;
		end
	end

	a_frame_period: assert property (@(posedge clk) disable iff (!rst_n)
		frame_tick |-> $past(cnt_reg) == 5'h17 && $past(disp_clk_tick))
		else $error("frame tick not after 24 periods");
endmodule

// *** logic/lcdi2c_slave.sv ***
// Purpose: write-only serial slave front end of a segment display driver
// Assumes: bus pins sampled by the 40 MHz clock; ack pin is open drain
// Notes: command decode and RAM live outside; subaddr_sel comes from them
`timescale 1ns/100ps
`include "lcdi2c_defs.svh"
module lcdi2c_slave (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_pin,
	input wire logic sda_pin,
	input wire logic addr_lsb_strap,
	input wire logic hw_subaddr_bit0,
	input wire logic hw_subaddr_bit1,
	input wire logic hw_subaddr_bit2,
	input wire logic [2:0] subaddr_sel,
	input wire logic [`LCDI2C_PTR_W-1:0] data_ptr,
	input wire logic disp_clk_tick,
	output logic ack_output_pin_out,
	output logic ack_output_pin_oe,
	output logic cmd_valid,
	output logic [7:0] cmd_byte,
	output logic ram_wr_valid,
	output lcdi2c_pkg::lcdi2c_ram_wr_s ram_wr,
	output logic busy,
	output logic frame_tick
);
	//==========================================================
	// Pin synchronisers
	logic [5:0] pins_sync;
	logic scl_s;
	logic sda_s;
	lcdi2c_pkg::lcdi2c_straps_s straps;

	lcdi2c_sync2 #(.W(6)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({scl_pin, sda_pin, hw_subaddr_bit2, hw_subaddr_bit1, hw_subaddr_bit0,
			addr_lsb_strap}),
		.q(pins_sync)
	);
	assign scl_s = pins_sync[5];
	assign sda_s = pins_sync[4];
	assign straps = lcdi2c_pkg::lcdi2c_straps_s'(pins_sync[3:0]);

	lcdi2c_frame_div u_frame (
		.clk(clk),
		.rst_n(rst_n),
		.disp_clk_tick(disp_clk_tick),
		.frame_tick(frame_tick)
	);

	//==========================================================
	// Bus edge and condition detect
	logic scl_d_reg;
	logic sda_d_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end
	assign scl_rise = scl_s && !scl_d_reg;
	assign scl_fall = !scl_s && scl_d_reg;
	// Both wait one cycle of stable SCL high so a data edge is not misread
	assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
	assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;

	//==========================================================
	// Byte framing and protocol
	lcdi2c_pkg::lcdi2c_phase_e phase_reg;
	lcdi2c_pkg::lcdi2c_phase_e phase_next;
	logic [3:0] bit_reg;
	logic [3:0] bit_next;
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic active_reg;
	logic active_next;
	logic more_ctl_reg;
	logic more_ctl_next;
	logic data_sel_reg;
	logic data_sel_next;
	logic ack_reg;
	logic ack_next;
	logic cmd_valid_next;
	logic [7:0] cmd_byte_next;
	logic ram_valid_next;
	lcdi2c_pkg::lcdi2c_ram_wr_s ram_wr_next;
	logic [7:0] rx_byte;
	logic want_ack;
	logic sub_match;

	assign rx_byte = {shift_reg[6:0], sda_s};
	assign sub_match = (straps.hw_subaddr == subaddr_sel);

	always_comb begin
		phase_next = phase_reg;
		bit_next = bit_reg;
		shift_next = shift_reg;
		active_next = active_reg;
		more_ctl_next = more_ctl_reg;
		data_sel_next = data_sel_reg;
		ack_next = ack_reg;
		cmd_valid_next = 1'b0;
		cmd_byte_next = cmd_byte;
		ram_valid_next = 1'b0;
		ram_wr_next = ram_wr;
		want_ack = 1'b0;
		if (start_det) begin
			phase_next = lcdi2c_pkg::LCDI2C_PH_ADDR;
			bit_next = 4'h0;
			active_next = 1'b1;
			ack_next = 1'b0;
		end else if (stop_det) begin
			active_next = 1'b0;
			ack_next = 1'b0;
			phase_next = lcdi2c_pkg::LCDI2C_PH_IGNORE;
		end else if (active_reg && scl_rise && bit_reg < 4'h8) begin
			shift_next = rx_byte;
			bit_next = bit_reg + 4'h1;
			if (bit_reg == 4'h7) begin
				unique case (phase_reg)
					lcdi2c_pkg::LCDI2C_PH_ADDR: begin
						if (rx_byte[7:2] == `LCDI2C_ADDR_HI6
							&& rx_byte[1] == straps.addr_lsb_strap
							&& !rx_byte[0]) begin
							want_ack = 1'b1;
							phase_next = lcdi2c_pkg::LCDI2C_PH_CTRL;
						end else begin
							phase_next = lcdi2c_pkg::LCDI2C_PH_IGNORE;
						end
					end
					lcdi2c_pkg::LCDI2C_PH_CTRL: begin
						want_ack = 1'b1;
						more_ctl_next = rx_byte[`LCDI2C_CTL_MORE_BIT];
						data_sel_next = rx_byte[`LCDI2C_CTL_DATA_BIT];
						phase_next = lcdi2c_pkg::LCDI2C_PH_PAYLOAD;
					end
					lcdi2c_pkg::LCDI2C_PH_PAYLOAD: begin
						if (data_sel_reg) begin
							want_ack = sub_match;
							ram_valid_next = sub_match;
							ram_wr_next.ptr = data_ptr;
							ram_wr_next.subaddr = subaddr_sel;
							ram_wr_next.data = rx_byte;
						end else begin
							want_ack = 1'b1;
							cmd_valid_next = 1'b1;
							cmd_byte_next = rx_byte;
						end
						if (more_ctl_reg) begin
							phase_next = lcdi2c_pkg::LCDI2C_PH_CTRL;
						end
					end
					lcdi2c_pkg::LCDI2C_PH_IGNORE: begin
						want_ack = 1'b0;
					end
				endcase
				ack_next = want_ack;
			end
		end else if (active_reg && scl_fall && bit_reg == 4'h8) begin
			// Ack low is held from this fall through the ninth clock high
			bit_next = 4'h9;
		end else if (active_reg && scl_fall && bit_reg == 4'h9) begin
			ack_next = 1'b0;
			bit_next = 4'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= lcdi2c_pkg::LCDI2C_PH_IGNORE;
			bit_reg <= 4'h0;
			shift_reg <= 8'h00;
			active_reg <= 1'b0;
			more_ctl_reg <= 1'b0;
			data_sel_reg <= 1'b0;
			ack_reg <= 1'b0;
			cmd_valid <= 1'b0;
			cmd_byte <= 8'h00;
			ram_wr_valid <= 1'b0;
			ram_wr <= '0;
		end else begin
			phase_reg <= phase_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			active_reg <= active_next;
			more_ctl_reg <= more_ctl_next;
			data_sel_reg <= data_sel_next;
			ack_reg <= ack_next;
			cmd_valid <= cmd_valid_next;
			cmd_byte <= cmd_byte_next;
			ram_wr_valid <= ram_valid_next;
			ram_wr <= ram_wr_next;
		end
	end

	// Ack only once SCL is low after the eighth bit, never during data high
	assign ack_output_pin_oe = ack_reg && (bit_reg == 4'h9);
	assign ack_output_pin_out = 1'b0;
	assign busy = active_reg;

	//==========================================================
	// Checks
	// Byte end is the eighth SCL rise inside an active transfer
	sequence s_byte_end;
		active_reg && scl_rise && bit_reg == 4'h7 && !start_det && !stop_det;
	endsequence
	sequence s_addr_end;
		phase_reg == lcdi2c_pkg::LCDI2C_PH_ADDR && scl_rise && bit_reg == 4'h7 && active_reg
			&& !start_det && !stop_det;
	endsequence
	sequence s_ctl_end;
		s_byte_end ##0 phase_reg == lcdi2c_pkg::LCDI2C_PH_CTRL;
	endsequence
	sequence s_pay_end;
		s_byte_end ##0 phase_reg == lcdi2c_pkg::LCDI2C_PH_PAYLOAD;
	endsequence

	// Address phase
	a_read_no_ack: assert property (@(posedge clk) disable iff (!rst_n)
		s_addr_end ##0 sda_s |=> !ack_reg)
		else $error("read address acknowledged");
	a_addr_match: assert property (@(posedge clk) disable iff (!rst_n)
		s_addr_end ##0 (!sda_s && rx_byte[7:1] == {`LCDI2C_ADDR_HI6, straps.addr_lsb_strap})
		|=> ack_reg && phase_reg == lcdi2c_pkg::LCDI2C_PH_CTRL)
		else $error("matching address not acknowledged");
	a_addr_filter: assert property (@(posedge clk) disable iff (!rst_n)
		s_addr_end ##0 rx_byte[7:2] != `LCDI2C_ADDR_HI6
		|=> phase_reg == lcdi2c_pkg::LCDI2C_PH_IGNORE)
		else $error("foreign address accepted");
	a_lsb_filter: assert property (@(posedge clk) disable iff (!rst_n)
		s_addr_end ##0 (rx_byte[1] != straps.addr_lsb_strap)
		|=> phase_reg == lcdi2c_pkg::LCDI2C_PH_IGNORE && !ack_reg)
		else $error("other address lsb accepted");
	a_ignore_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		phase_reg == lcdi2c_pkg::LCDI2C_PH_IGNORE |-> !ack_output_pin_oe && !ram_wr_valid
		&& !cmd_valid)
		else $error("ignored transfer produced activity");
	a_start_frame: assert property (@(posedge clk) disable iff (!rst_n)
		start_det |=> phase_reg == lcdi2c_pkg::LCDI2C_PH_ADDR && bit_reg == 4'h0)
		else $error("start did not reset framing");

	// Control and payload
	a_ctl_data_sel: assert property (@(posedge clk) disable iff (!rst_n)
		s_ctl_end |=> data_sel_reg == shift_reg[`LCDI2C_CTL_DATA_BIT])
		else $error("control data select decoded wrong");
	a_ctl_more: assert property (@(posedge clk) disable iff (!rst_n)
		s_ctl_end |=> more_ctl_reg == shift_reg[`LCDI2C_CTL_MORE_BIT])
		else $error("control continue flag decoded wrong");
	a_ctl_ack: assert property (@(posedge clk) disable iff (!rst_n)
		s_ctl_end |=> ack_reg)
		else $error("control byte not acknowledged");
	a_cmd_take: assert property (@(posedge clk) disable iff (!rst_n)
		s_pay_end ##0 !data_sel_reg
		|=> cmd_valid && cmd_byte == shift_reg && ack_reg)
		else $error("command byte not passed on");
	a_cmd_ack: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_valid |-> ack_reg)
		else $error("command byte not acknowledged");
	a_data_write: assert property (@(posedge clk) disable iff (!rst_n)
		s_pay_end ##0 (data_sel_reg && sub_match)
		|=> ram_wr_valid && ram_wr.data == shift_reg && ram_wr.ptr == $past(data_ptr))
		else $error("display byte not written at pointer");
	a_data_silent: assert property (@(posedge clk) disable iff (!rst_n)
		s_pay_end ##0 (data_sel_reg && !sub_match)
		|=> !ram_wr_valid && !ack_reg)
		else $error("display byte taken by other subaddress");
	a_data_ack_sub: assert property (@(posedge clk) disable iff (!rst_n)
		ram_wr_valid |-> ack_reg && straps.hw_subaddr == ram_wr.subaddr)
		else $error("data ack without subaddress match");
	a_pay_next: assert property (@(posedge clk) disable iff (!rst_n)
		s_pay_end |=> (phase_reg == lcdi2c_pkg::LCDI2C_PH_CTRL) == $past(more_ctl_reg))
		else $error("phase after payload byte wrong");

	// Acknowledge pin
	a_ack_window: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(ack_output_pin_oe) |-> !scl_s && bit_reg == 4'h9 && !ack_output_pin_out)
		else $error("ack driven outside ninth clock");
	a_ack_release: assert property (@(posedge clk) disable iff (!rst_n)
		ack_output_pin_oe && scl_fall |=> !ack_output_pin_oe)
		else $error("ack held past ninth clock");
	a_stop_idle: assert property (@(posedge clk) disable iff (!rst_n)
		stop_det |=> !busy && !ack_output_pin_oe)
		else $error("stop did not end transfer");
endmodule

// *** testbench/lcdi2c_bus_master.sv ***
// Purpose: serial bus master model that writes to the display slave
// Assumes: data line has a pull-up; tb resolves it with the ack pin
// Notes: released data reads high through the pull-up
`timescale 1ns/100ps
module lcdi2c_bus_master (
	input wire logic clk,
	input wire logic sda_in,
	output logic scl,
	output logic sda
);
	// ==========================================
	// Bit timing
	localparam int H = 8;
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic hw(input int n);
		repeat (n) @(negedge clk);
	endtask
	// ==========================================
	// Conditions and bytes
	// Data moves two cycles after SCL falls, so it never looks like a condition
	task automatic start_c();
		sda = 1'b1;
		hw(2);
		scl = 1'b1;
		hw(H);
		sda = 1'b0;
		hw(H);
		scl = 1'b0;
		hw(2);
	endtask
	task automatic stop_c();
		sda = 1'b0;
		hw(H);
		scl = 1'b1;
		hw(H);
		sda = 1'b1;
		hw(H);
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		for (int i = 0; i < 9; i++) begin
			sda = (i < 8) ? b[7-i] : 1'b1;
			hw(H);
			scl = 1'b1;
			hw(H);
			ack = ~sda_in;
			scl = 1'b0;
			hw(2);
		end
	endtask
endmodule

// *** testbench/tb.sv ***
// Purpose: self-checking bench for the display driver serial slave
// Assumes: 40 MHz clock; inputs driven at falling edge
// Notes: bus traffic comes from the master model
`timescale 1ns/100ps
module tb;
	logic clk, rst_n, scl, m_sda, tick, ack, oe, ack_out;
	logic cmd_valid, ram_wr_valid, busy, frame_tick;
	lcdi2c_pkg::lcdi2c_straps_s st;
	logic [2:0] sel;
	logic [6:0] ptr;
	logic [7:0] cmd_byte, last_cmd;
	lcdi2c_pkg::lcdi2c_ram_wr_s ram_wr, last_wr;
	int err_count, cmp_count, ncmd, nwr, nfr, cyc;
	wire sda_line = m_sda & ~oe;
	lcdi2c_bus_master lcdi2c_bus_master_i (.clk(clk), .sda_in(sda_line), .scl(scl), .sda(m_sda));
	lcdi2c_slave lcdi2c_slave_i (.clk(clk), .rst_n(rst_n), .scl_pin(scl), .sda_pin(sda_line),
		.addr_lsb_strap(st.addr_lsb_strap), .hw_subaddr_bit0(st.hw_subaddr[0]),
		.hw_subaddr_bit1(st.hw_subaddr[1]), .hw_subaddr_bit2(st.hw_subaddr[2]),
		.subaddr_sel(sel), .data_ptr(ptr), .disp_clk_tick(tick),
		.ack_output_pin_out(ack_out), .ack_output_pin_oe(oe), .cmd_valid(cmd_valid),
		.cmd_byte(cmd_byte), .ram_wr_valid(ram_wr_valid), .ram_wr(ram_wr), .busy(busy),
		.frame_tick(frame_tick));
	// ==========================================
	// Clock, pulse capture and hang guard
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(negedge clk) begin
		cyc++;
		if (cmd_valid === 1'b1) begin
			ncmd++;
			last_cmd = cmd_byte;
		end
		if (ram_wr_valid === 1'b1) begin
			nwr++;
			last_wr = ram_wr;
		end
		if (frame_tick === 1'b1) nfr++;
		if (cyc == 20000) begin
			err_count++;
			report_and_stop();
		end
	end
	// ==========================================
	// Checks and bus steps
	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [17:0] g, input logic [17:0] e);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic [7:0] b, input logic e);
		lcdi2c_bus_master_i.wbyte(b, ack);
		chk(18'(ack), 18'(e));
	endtask
	task automatic go();
		lcdi2c_bus_master_i.start_c();
	endtask
	initial begin
		rst_n = 1'b0;
		tick = 1'b0;
		st = 4'hc;
		sel = 3'h6;
		ptr = 7'h2a;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		// Full write: a command then data, ignored control bits set
		go();
		chk(18'(busy), 18'h1);
		wb(8'h70, 1'b1);
		wb(8'hbf, 1'b1);
		wb(8'h3c, 1'b1);
		chk(18'(last_cmd), 18'h3c);
		wb(8'h40, 1'b1);
		wb(8'ha5, 1'b1);
		chk(last_wr, {7'h2a, 3'h6, 8'ha5});
		wb(8'h5a, 1'b1);
		chk(18'(nwr * 256 + ncmd), 18'h201);
		chk(18'(ack_out), 18'h0);
		lcdi2c_bus_master_i.stop_c();
		chk(18'(busy), 18'h0);
		// Other subaddress selected: data silent, commands still taken
		sel = 3'h3;
		go();
		wb(8'h70, 1'b1);
		wb(8'hc0, 1'b1);
		wb(8'h11, 1'b0);
		chk(18'(nwr), 18'h2);
		wb(8'h00, 1'b1);
		wb(8'h22, 1'b1);
		chk(18'(last_cmd), 18'h22);
		// Other address LSB ignored until a repeated start
		go();
		wb(8'h72, 1'b0);
		wb(8'h00, 1'b0);
		wb(8'h33, 1'b0);
		chk(18'(ncmd), 18'h2);
		go();
		wb(8'h70, 1'b1);
		go();
		wb(8'h71, 1'b0);
		wb(8'h00, 1'b0);
		lcdi2c_bus_master_i.stop_c();
		// Strap high moves the accepted address
		st.addr_lsb_strap = 1'b1;
		repeat (4) @(negedge clk);
		go();
		wb(8'h72, 1'b1);
		go();
		wb(8'h70, 1'b0);
		go();
		wb(8'h78, 1'b0);
		go();
		wb(8'h73, 1'b0);
		lcdi2c_bus_master_i.stop_c();
		// Frame every 24 display clocks
		for (int i = 1; i <= 48; i++) begin
			@(negedge clk) tick = 1'b1;
			@(negedge clk) tick = 1'b0;
			if (i == 23 || i == 48) begin
				repeat (4) @(negedge clk);
				chk(18'(nfr), (i == 23) ? 18'h0 : 18'h2);
			end
		end
		report_and_stop();
	end
endmodule
